// >>> tpw_pkg.sv
// shared constants and types of the tape write command handler
package tpw_pkg;
    localparam logic [7:0]  OP_WRITE     = 8'h0a;
    localparam logic [7:0]  OP_REWIND    = 8'h01;
    localparam logic [7:0]  OP_WFM       = 8'h10;
    localparam logic [7:0]  OP_SPACE     = 8'h11;
    localparam logic [7:0]  OP_ERASE     = 8'h19;
    localparam logic [7:0]  OP_LOAD      = 8'h1b;
    localparam logic [7:0]  OP_LOCATE    = 8'h2b;
    localparam logic [3:0]  KEY_NONE     = 4'h0;
    localparam logic [3:0]  KEY_ILLEGAL  = 4'h5;
    localparam logic [7:0]  ASC_FIXVAR   = 8'h81;
    localparam logic [7:0]  ASC_NONE     = 8'h00;
    localparam logic [7:0]  ASC_BADOP    = 8'h20;
    localparam logic [7:0]  ASC_BADLEN   = 8'h24;
    localparam logic [7:0]  ASC_BADPOS   = 8'h50;
    localparam logic [7:0]  ASC_FMTMIX   = 8'h30;
    localparam logic [23:0] MAX_VAR_LEN  = 24'h03c000;
    localparam logic [23:0] MAX_ND_LEN   = 24'h028000;
    localparam logic [23:0] BLKLEN_RST   = 24'h000400;
    localparam logic [23:0] MTHR_RST     = 24'h080000;
    // register byte offsets
    localparam logic [5:0]  A_CDB_LO     = 6'h00;
    localparam logic [5:0]  A_CDB_HI     = 6'h04;
    localparam logic [5:0]  A_CTRL       = 6'h08;
    localparam logic [5:0]  A_CFG        = 6'h0c;
    localparam logic [5:0]  A_BLKLEN     = 6'h10;
    localparam logic [5:0]  A_WDELAY     = 6'h14;
    localparam logic [5:0]  A_MTHR       = 6'h18;
    localparam logic [5:0]  A_STATUS     = 6'h1c;
    localparam logic [5:0]  A_OTHER      = 6'h20;
    localparam logic [5:0]  A_COUNT      = 6'h24;
    // write delay unit and its cycle count at 20 MHz
    localparam longint      WDT_UNIT_NS  = 100_000_000;
    localparam longint      CLK_NS       = 50;
    localparam int          WDT_UNIT_CYC = int'(WDT_UNIT_NS / CLK_NS);
    // tape position reported by the transport
    typedef enum logic [2:0] {
        TPW_POS_LOGICAL_TAPE_BEGINNING   = 3'h0,
        TPW_POS_FM_BOT = 3'h1,
        TPW_POS_FM_EOT = 3'h2,
        TPW_POS_EOD    = 3'h3,
        TPW_POS_BLANK  = 3'h4,
        TPW_POS_OTHER  = 3'h5
    } tpw_pos_t;
    typedef struct packed {
        logic [2:0] buf_mode;
        logic       disc_en;
        logic       pf;
        logic       legacy;
        logic       nd;
    } tpw_cfg_t;
    typedef struct packed {
        logic       check;
        logic [3:0] key;
        logic [7:0] asc;
        logic [7:0] ascq;
    } tpw_sense_t;
    typedef enum logic [2:0] {
        TPW_IDLE  = 3'b000,
        TPW_CHECK = 3'b001,
        TPW_LBOTW = 3'b011,
        TPW_XFER  = 3'b010,
        TPW_DRAIN = 3'b110,
        TPW_DONE  = 3'b111
    } tpw_state_t;
endpackage

// >>> tpw_cdb_check.sv
// command block decode and legality check for the write command
`timescale 1ns/1ps
`default_nettype none
module tpw_cdb_check (
    // command and settings
    input  wire logic [47:0]         cdb_i,
    input  wire tpw_pkg::tpw_cfg_t   cfg_i,
    input  wire logic [23:0]         blklen_i,
    // transport
    input  wire tpw_pkg::tpw_pos_t   pos_i,
    input  wire logic                tape_legacy_i,
    // result
    output tpw_pkg::tpw_sense_t      err_o,
    output logic [47:0]              total_o,
    output logic                     zero_o
);
    logic [7:0]  op;
    logic        fixed;
    logic [23:0] len;
    logic        pos_ok;
    assign op    = cdb_i[47:40];
    assign fixed = cdb_i[32];
    assign len   = cdb_i[31:8];
    assign zero_o = (len == '0);
    assign total_o = fixed ? 48'(len) * 48'(blklen_i) : {24'h000000, len};
    always_comb begin
        if (cfg_i.legacy) begin
            pos_ok = pos_i == tpw_pkg::TPW_POS_FM_BOT
                  || pos_i == tpw_pkg::TPW_POS_BLANK;
        end else begin
            pos_ok = pos_i == tpw_pkg::TPW_POS_FM_BOT
                  || pos_i == tpw_pkg::TPW_POS_FM_EOT
                  || pos_i == tpw_pkg::TPW_POS_EOD;
        end
        pos_ok = pos_ok || pos_i == tpw_pkg::TPW_POS_LOGICAL_TAPE_BEGINNING;
    end
    always_comb begin
        err_o = '{check: 1'b1, key: tpw_pkg::KEY_ILLEGAL,
                  asc: tpw_pkg::ASC_NONE, ascq: tpw_pkg::ASC_NONE};
        if (op != tpw_pkg::OP_WRITE) begin
            err_o.asc = tpw_pkg::ASC_BADOP;
        end else if (fixed != (blklen_i != '0)) begin
            err_o.asc = tpw_pkg::ASC_FIXVAR;
        end else if (!fixed && len > (cfg_i.nd ? tpw_pkg::MAX_ND_LEN
                                               : tpw_pkg::MAX_VAR_LEN)) begin
            err_o.asc = tpw_pkg::ASC_BADLEN;
        end else if (zero_o) begin
            err_o = '0;
        end else if (!pos_ok) begin
            err_o.asc = tpw_pkg::ASC_BADPOS;
        end else if (pos_i != tpw_pkg::TPW_POS_LOGICAL_TAPE_BEGINNING && tape_legacy_i != cfg_i.legacy) begin
            err_o.asc = tpw_pkg::ASC_FMTMIX;
        end else begin
            err_o = '0;
        end
    end
endmodule
`default_nettype wire

// >>> tpw_delay_timer.sv
// write delay timer: pulses when a partly filled buffer sat idle too long
`timescale 1ns/1ps
`default_nettype none
module tpw_delay_timer #(
    parameter int UNIT_CYC = tpw_pkg::WDT_UNIT_CYC
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    // control
    input  wire logic       arm_i,
    input  wire logic [7:0] delay_i,
    // event
    output logic            expire_o
);
    typedef struct packed {
        logic [31:0] tick;
        logic [7:0]  units;
        logic        expire;
    } tpw_tmr_t;
    tpw_tmr_t st;
    tpw_tmr_t next_st;
    always_comb begin
        next_st = st;
        next_st.expire = 1'b0;
        // disarming restarts the wait, so any new write activity defers the flush
        if (!arm_i || delay_i == '0) begin
            next_st.tick  = '0;
            next_st.units = '0;
        end else if (st.tick == 32'(UNIT_CYC - 1)) begin
            next_st.tick  = '0;
            next_st.units = st.units + 8'h01;
            next_st.expire = (st.units + 8'h01 == delay_i);
        end else begin
            next_st.tick = st.tick + 32'h1;
        end
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign expire_o = st.expire;
endmodule
`default_nettype wire

// >>> tpw_write_cmd.sv
// write command handler top: register slave, command sequencing, flush control
// Behaviour
// - accept six-byte opcode 0Ah as a write
// - fixed clear: one block of length bytes
// - fixed set: length counts blocks of set length
// - fixed clear, nonzero block length: illegal, 81h/00h
// - fixed set, zero block length: illegal, mismatch
// - length is bytes 2..4; variable up to 240K
// - no-disconnect setting limits variable block to 160K
// - zero length moves nothing, keeps position
// - at beginning write fresh pattern first
// - native format appends at filemarks or data end
// - legacy format appends at filemark start, blank
// - format from settings, never mixed on cartridge
// - buffer mode from header bits 6..4
// - unbuffered: good only after tape recorded
// - buffered: good once data is in buffer
// - flush when fill reaches motion threshold
// - listed positioning commands flush the buffer
// - unload button press flushes the buffer
// - write delay expiry flushes; zero disables it
// - write delay honoured only with page format
// - disconnect allowed during write when enabled
`timescale 1ns/1ps
`default_nettype none
module tpw_write_cmd #(
    parameter int WDT_CYC = tpw_pkg::WDT_UNIT_CYC
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    // avalon-mm slave
    input  wire logic [5:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // data-out stream from the initiator
    input  wire logic              din_valid_i,
    input  wire logic [7:0]        din_data_i,
    output logic                   din_ready_o,
    // toward the buffer
    output logic                   buf_valid_o,
    output logic [7:0]             buf_data_o,
    input  wire logic              buf_full_i,
    input  wire logic              buf_empty_i,
    input  wire logic [23:0]       buf_fill_i,
    // transport
    input  wire tpw_pkg::tpw_pos_t tape_pos_i,
    input  wire logic              tape_legacy_i,
    input  wire logic              tape_idle_i,
    input  wire logic              logical_tape_beginning_done_i,
    input  wire logic              unload_btn_i,
    output logic                   logical_tape_beginning_write_o,
    output logic                   logical_tape_beginning_legacy_o,
    output logic                   flush_o,
    // bus phase
    output logic                   disc_ok_o
);
    typedef struct packed {
        tpw_pkg::tpw_state_t fsm;
        logic                wait_r;
        logic [31:0]         rdata;
        logic [47:0]         cdb;
        tpw_pkg::tpw_cfg_t   cfg;
        logic [23:0]         blklen;
        logic [7:0]          wdelay;
        logic [23:0]         mthr;
        tpw_pkg::tpw_sense_t sense;
        logic [47:0]         total;
        logic [47:0]         cnt;
        logic                done;
        logic                flush;
        logic                dready;
        logic                bvalid;
        logic [7:0]          bdata;
        logic                lbotw;
        logic                disc;
        logic                btn_q;
    } tpw_top_t;

    tpw_top_t st;
    tpw_top_t next_st;

    tpw_pkg::tpw_sense_t chk_err;
    logic [47:0]         chk_total;
    logic                chk_zero;
    logic                wdt_expire;
    logic                bus_req;
    logic                take;
    logic                accept;

    tpw_cdb_check u_check (
        .cdb_i         (st.cdb),
        .cfg_i         (st.cfg),
        .blklen_i      (st.blklen),
        .pos_i         (tape_pos_i),
        .tape_legacy_i (tape_legacy_i),
        .err_o         (chk_err),
        .total_o       (chk_total),
        .zero_o        (chk_zero)
    );

    // timer runs only while data waits in the buffer and no write is active
    tpw_delay_timer #(
        .UNIT_CYC (WDT_CYC)
    ) u_timer (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .arm_i     (st.cfg.pf && !buf_empty_i && st.fsm == tpw_pkg::TPW_IDLE),
        .delay_i   (st.wdelay),
        .expire_o  (wdt_expire)
    );

    function automatic logic is_flush_op(input logic [7:0] op, input logic immed,
                                         input logic rev);
        case (op)
            tpw_pkg::OP_REWIND,
            tpw_pkg::OP_SPACE,
            tpw_pkg::OP_ERASE,
            tpw_pkg::OP_LOAD:   is_flush_op = 1'b1;
            tpw_pkg::OP_WFM:    is_flush_op = !immed;
            tpw_pkg::OP_LOCATE: is_flush_op = rev;
            default:            is_flush_op = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] reg_read(input tpw_top_t s, input logic [5:0] a);
        case (a)
            tpw_pkg::A_CDB_LO: reg_read = s.cdb[31:0];
            tpw_pkg::A_CDB_HI: reg_read = {16'h0000, s.cdb[47:32]};
            tpw_pkg::A_CFG:    reg_read = {25'h0000000, s.cfg};
            tpw_pkg::A_BLKLEN: reg_read = {8'h00, s.blklen};
            tpw_pkg::A_WDELAY: reg_read = {24'h000000, s.wdelay};
            tpw_pkg::A_MTHR:   reg_read = {8'h00, s.mthr};
            tpw_pkg::A_STATUS: reg_read = {s.sense.ascq, s.sense.asc, s.sense.key,
                                           s.done, s.flush, s.sense.check,
                                           s.fsm != tpw_pkg::TPW_IDLE, 8'h00};
            tpw_pkg::A_COUNT:  reg_read = s.cnt[31:0];
            default:           reg_read = 32'h00000000;
        endcase
    endfunction

    assign bus_req = avs_read_i || avs_write_i;
    assign take    = bus_req && !st.wait_r;
    assign accept  = din_valid_i && st.dready;

    always_comb begin
        next_st = st;
        next_st.bvalid = 1'b0;
        // one wait cycle: read data is registered from a stable address
        if (bus_req && st.wait_r) begin
            next_st.wait_r = 1'b0;
            next_st.rdata  = reg_read(st, avs_address_i);
        end else begin
            next_st.wait_r = 1'b1;
        end
        // flush ends when the tape engine has emptied the buffer; cleared before any set
        if (st.flush && buf_empty_i && tape_idle_i && st.fsm != tpw_pkg::TPW_XFER) begin
            next_st.flush = 1'b0;
        end
        if (take && avs_write_i) begin
            case (avs_address_i)
                tpw_pkg::A_CDB_LO: next_st.cdb[31:0]  = avs_writedata_i;
                tpw_pkg::A_CDB_HI: next_st.cdb[47:32] = avs_writedata_i[15:0];
                tpw_pkg::A_CFG:    next_st.cfg        = avs_writedata_i[6:0];
                tpw_pkg::A_BLKLEN: next_st.blklen     = avs_writedata_i[23:0];
                tpw_pkg::A_WDELAY: next_st.wdelay     = avs_writedata_i[7:0];
                tpw_pkg::A_MTHR:   next_st.mthr       = avs_writedata_i[23:0];
                tpw_pkg::A_CTRL: begin
                    if (avs_writedata_i[0] && st.fsm == tpw_pkg::TPW_IDLE) begin
                        next_st.fsm  = tpw_pkg::TPW_CHECK;
                        next_st.done = 1'b0;
                    end
                end
                tpw_pkg::A_OTHER: begin
                    if (is_flush_op(avs_writedata_i[7:0], avs_writedata_i[8],
                                    avs_writedata_i[9])) begin
                        next_st.flush = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        next_st.btn_q = unload_btn_i;
        if (unload_btn_i && !st.btn_q) begin
            next_st.flush = 1'b1;
        end
        if (wdt_expire) begin
            next_st.flush = 1'b1;
        end
        case (st.fsm)
            tpw_pkg::TPW_IDLE: begin
                next_st.disc = 1'b0;
            end
            tpw_pkg::TPW_CHECK: begin
                next_st.sense = chk_err;
                next_st.total = chk_total;
                next_st.cnt   = '0;
                next_st.disc  = st.cfg.disc_en;
                if (chk_err.check || chk_zero) begin
                    next_st.fsm = tpw_pkg::TPW_DONE;
                end else if (tape_pos_i == tpw_pkg::TPW_POS_LOGICAL_TAPE_BEGINNING) begin
                    next_st.fsm   = tpw_pkg::TPW_LBOTW;
                    next_st.lbotw = 1'b1;
                end else begin
                    next_st.fsm    = tpw_pkg::TPW_XFER;
                    next_st.dready = !buf_full_i;
                end
            end
            tpw_pkg::TPW_LBOTW: begin
                if (logical_tape_beginning_done_i) begin
                    next_st.lbotw  = 1'b0;
                    next_st.fsm    = tpw_pkg::TPW_XFER;
                    next_st.dready = !buf_full_i;
                end
            end
            tpw_pkg::TPW_XFER: begin
                if (accept) begin
                    next_st.cnt    = st.cnt + 48'h1;
                    next_st.bvalid = 1'b1;
                    next_st.bdata  = din_data_i;
                end
                next_st.dready = (next_st.cnt != st.total) && !buf_full_i;
                if (buf_fill_i >= st.mthr) begin
                    next_st.flush = 1'b1;
                end
                if (next_st.cnt == st.total) begin
                    if (st.cfg.buf_mode == 3'h0) begin
                        next_st.fsm   = tpw_pkg::TPW_DRAIN;
                        next_st.flush = 1'b1;
                    end else begin
                        next_st.fsm = tpw_pkg::TPW_DONE;
                    end
                end
            end
            tpw_pkg::TPW_DRAIN: begin
                next_st.flush = 1'b1;
                // status held until the last byte is on tape
                if (buf_empty_i && tape_idle_i && st.flush) begin
                    next_st.fsm = tpw_pkg::TPW_DONE;
                end
            end
            tpw_pkg::TPW_DONE: begin
                next_st.done = 1'b1;
                next_st.disc = 1'b0;
                next_st.fsm  = tpw_pkg::TPW_IDLE;
            end
            default: next_st.fsm = tpw_pkg::TPW_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st        <= '0;
            st.wait_r <= 1'b1;
            st.blklen <= tpw_pkg::BLKLEN_RST;
            st.mthr   <= tpw_pkg::MTHR_RST;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_o    = st.rdata;
    assign avs_waitrequest_o = st.wait_r;
    assign din_ready_o       = st.dready;
    assign buf_valid_o       = st.bvalid;
    assign buf_data_o        = st.bdata;
    assign logical_tape_beginning_write_o      = st.lbotw;
    assign logical_tape_beginning_legacy_o     = st.cfg.legacy;
    assign flush_o           = st.flush;
    assign disc_ok_o         = st.disc;

    a_mismatch_sense: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == tpw_pkg::TPW_CHECK && st.cdb[47:40] == tpw_pkg::OP_WRITE
        && !st.cdb[32] && st.blklen != '0
        |=> st.sense.asc == tpw_pkg::ASC_FIXVAR && st.sense.key == tpw_pkg::KEY_ILLEGAL)
        else $error("mismatch not reported");
    a_fixed_zero_len: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == tpw_pkg::TPW_CHECK && st.cdb[47:40] == tpw_pkg::OP_WRITE
        && st.cdb[32] && st.blklen == '0 |=> st.sense.check ##1 st.fsm == tpw_pkg::TPW_IDLE)
        else $error("fixed with zero length accepted");
    a_zero_no_data: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == tpw_pkg::TPW_CHECK && chk_zero
        |=> !st.dready && !st.lbotw && st.fsm == tpw_pkg::TPW_DONE)
        else $error("zero length moved data");
    a_unbuf_good: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == tpw_pkg::TPW_DRAIN && !(buf_empty_i && tape_idle_i)
        |=> st.fsm == tpw_pkg::TPW_DRAIN && !st.done)
        else $error("unbuffered done before tape");
    a_buf_good: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == tpw_pkg::TPW_XFER && st.cfg.buf_mode != 3'h0 && next_st.cnt == st.total
        |=> st.fsm == tpw_pkg::TPW_DONE ##1 st.done)
        else $error("buffered completion late");
    a_unload_flush: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        unload_btn_i && !st.btn_q |=> st.flush)
        else $error("unload did not flush");
    a_rewind_flush: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        take && avs_write_i && avs_address_i == tpw_pkg::A_OTHER
        && avs_writedata_i[7:0] == tpw_pkg::OP_REWIND |=> st.flush)
        else $error("rewind did not flush");
    a_ready_bound: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.dready |-> st.fsm == tpw_pkg::TPW_XFER && st.cnt != st.total)
        else $error("ready beyond transfer length");
    a_logical_tape_beginning_first: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.lbotw |-> !st.dready && st.cnt == '0)
        else $error("data before pattern");
endmodule
`default_nettype wire

// >>> tpw_far_model.sv
// buffer and transport model standing behind the write handler
`timescale 1ns/1ps
`default_nettype none
module tpw_far_model #(
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   resetn_i,
    // from the handler
    input  wire logic   buf_valid_i,
    input  wire logic   flush_i,
    input  wire logic   logical_tape_beginning_write_i,
    // to the handler
    output logic        full_o,
    output logic        empty_o,
    output logic        idle_o,
    output logic        logical_tape_beginning_done_o,
    output logic [23:0] fill_o
);
    logic drain;
    // tape takes one byte a cycle while a flush is asked for
    assign drain = flush_i && (fill_o != 24'h0);
    // full two early: the handler sees it one cycle late
    assign full_o = fill_o >= 24'(DEPTH - 2);
    assign empty_o = fill_o == 24'h0;
    assign idle_o = !drain;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fill_o <= 24'h0;
            logical_tape_beginning_done_o <= 1'b0;
        end else begin
            fill_o <= fill_o + 24'(buf_valid_i) - 24'(drain);
            logical_tape_beginning_done_o <= logical_tape_beginning_write_i && !logical_tape_beginning_done_o;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench of the write command handler
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic din_valid_i = 1'b0, unload_btn_i = 1'b0, tape_legacy_i = 1'b0, rd_chk = 1'b0;
    logic [5:0] avs_address_i = 6'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic [7:0] din_data_i = 8'h0, buf_data_o;
    tpw_pkg::tpw_pos_t tape_pos_i = tpw_pkg::TPW_POS_EOD;
    logic avs_waitrequest_o, din_ready_o, buf_valid_o, buf_full_i, buf_empty_i, tape_idle_i;
    logic logical_tape_beginning_done_i, logical_tape_beginning_write_o, logical_tape_beginning_legacy_o, flush_o, disc_ok_o;
    logic [23:0] buf_fill_i;
    logic [63:0] exp_q[$], e;
    logic [7:0] byte_q[$];
    int bad_count = 0, n_compared = 0, nacc = 0, nfl = 0, nlb = 0, ndc = 0;
    tpw_write_cmd #(.WDT_CYC(10)) DUT (.sys_clk_i, .resetn_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .din_valid_i,
        .din_data_i, .din_ready_o, .buf_valid_o, .buf_data_o, .buf_full_i, .buf_empty_i,
        .buf_fill_i, .tape_pos_i, .tape_legacy_i, .tape_idle_i, .logical_tape_beginning_done_i, .unload_btn_i,
        .logical_tape_beginning_write_o, .logical_tape_beginning_legacy_o, .flush_o, .disc_ok_o);
    tpw_far_model FAR (.sys_clk_i, .resetn_i, .buf_valid_i(buf_valid_o), .flush_i(flush_o),
        .logical_tape_beginning_write_i(logical_tape_beginning_write_o), .full_o(buf_full_i), .empty_o(buf_empty_i),
        .idle_o(tape_idle_i), .logical_tape_beginning_done_o(logical_tape_beginning_done_i), .fill_o(buf_fill_i));
    always #25 sys_clk_i = !sys_clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        if (rd_chk && avs_read_i && avs_waitrequest_o === 1'b0) begin
            e = exp_q.pop_front();
            chk(avs_readdata_o & e[31:0], e[63:32]);
        end
        if (din_valid_i && din_ready_o === 1'b1) begin
            byte_q.push_back(din_data_i);
            nacc++;
        end
        if (buf_valid_o === 1'b1) chk(buf_data_o, byte_q.pop_front());
        if (logical_tape_beginning_write_o === 1'b1) chk(logical_tape_beginning_legacy_o, tape_legacy_i);
        nfl <= nfl + int'(flush_o === 1'b1);
        nlb <= nlb + int'(logical_tape_beginning_write_o === 1'b1);
        ndc <= ndc + int'(disc_ok_o === 1'b1);
        din_valid_i <= ($urandom % 4) != 0;
        din_data_i <= 8'($urandom);
    end
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic c,
                       output logic [31:0] q);
        int n;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        rd_chk <= c;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 100) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 1'b0, q);
    endtask
    task automatic exp_rd(input logic [5:0] a, input logic [31:0] x, input logic [31:0] m);
        logic [31:0] q;
        exp_q.push_back({x, m});
        bus(1'b0, a, 32'h0, 1'b1, q);
    endtask
    task automatic flush_by(input int cyc, input logic x);
        int s;
        s = nfl;
        repeat (cyc) @(posedge sys_clk_i);
        chk(nfl != s, x);
    endtask
    // cfg: [6:4] buffer mode, [3] disconnect, [2] page format, [1] legacy, [0] no disconnect
    task automatic cmd(input logic [6:0] cfg, input logic [23:0] bl, input logic fx,
                       input logic [23:0] len, input logic [2:0] pos, input logic [7:0] asc);
        logic [31:0] q;
        int n, a0;
        a0 = nacc;
        tape_pos_i <= tpw_pkg::tpw_pos_t'(pos);
        tape_legacy_i <= cfg[1] ^ (asc == tpw_pkg::ASC_FMTMIX);
        wr(tpw_pkg::A_CFG, {25'h0, cfg});
        wr(tpw_pkg::A_BLKLEN, {8'h0, bl});
        wr(tpw_pkg::A_CDB_LO, {len, 8'h0});
        wr(tpw_pkg::A_CDB_HI, {16'h0, (asc == tpw_pkg::ASC_BADOP) ? 8'h0b : tpw_pkg::OP_WRITE,
                               7'h0, fx});
        wr(tpw_pkg::A_CTRL, 32'h1);
        n = 0;
        do begin
            bus(1'b0, tpw_pkg::A_STATUS, 32'h0, 1'b0, q);
            n++;
        end while (q[8] !== 1'b0 && n < 500);
        if (n >= 500) begin
            bad_count++;
            test_done();
        end
        if (asc != 8'h0) exp_rd(tpw_pkg::A_STATUS, {8'h0, asc, 16'h5200}, 32'hffff_f200);
        else begin
            exp_rd(tpw_pkg::A_STATUS, 32'h800, 32'hffff_fa00);
            exp_rd(tpw_pkg::A_COUNT, fx ? len * bl : len, '1);
            chk(nacc - a0, fx ? len * bl : len);
            if (cfg[6:4] == 3'h0) chk(buf_empty_i, 1'b1);
        end
    endtask
    initial begin
        logic [31:0] ops [7];
        int s, lg, p, ok;
        ops = '{{24'h0, tpw_pkg::OP_REWIND}, {24'h0, tpw_pkg::OP_WFM}, {24'h0, tpw_pkg::OP_SPACE},
                {24'h0, tpw_pkg::OP_ERASE}, {24'h0, tpw_pkg::OP_LOAD}, {24'h2, tpw_pkg::OP_LOCATE},
                {24'h0, tpw_pkg::OP_LOCATE}};
        void'($urandom(32'he037));
        repeat (16) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        exp_rd(tpw_pkg::A_BLKLEN, 32'h400, '1);
        exp_rd(tpw_pkg::A_MTHR, 32'h80000, '1);
        exp_rd(6'h28, 32'h0, '1);
        cmd(7'h00, 24'h400, 1'b0, 24'h5, 3'h3, tpw_pkg::ASC_FIXVAR);
        cmd(7'h00, 24'h0, 1'b0, 24'h5, 3'h3, tpw_pkg::ASC_BADOP);
        cmd(7'h00, 24'h0, 1'b1, 24'h3, 3'h3, tpw_pkg::ASC_FIXVAR);
        cmd(7'h00, 24'h0, 1'b0, 24'h03c001, 3'h3, tpw_pkg::ASC_BADLEN);
        cmd(7'h01, 24'h0, 1'b0, 24'h028001, 3'h3, tpw_pkg::ASC_BADLEN);
        cmd(7'h00, 24'h0, 1'b0, 24'h0, 3'h3, 8'h0);
        cmd(7'h10, 24'h0, 1'b0, 24'($urandom_range(1, 16)), 3'h3, 8'h0);
        cmd(7'h10, 24'h4, 1'b1, 24'h3, 3'h2, 8'h0);
        for (lg = 0; lg < 2; lg++) begin
            for (p = 0; p < 6; p++) begin
                ok = lg ? int'(p == 0 || p == 1 || p == 4) : int'(p <= 3);
                s = nlb;
                cmd({5'h0, lg[0], 1'b0}, 24'h0, 1'b0, 24'h6, p[2:0],
                    ok ? 8'h0 : tpw_pkg::ASC_BADPOS);
                chk(nlb != s, p == 0);
            end
        end
        cmd(7'h02, 24'h0, 1'b0, 24'h6, 3'h1, tpw_pkg::ASC_FMTMIX);
        wr(tpw_pkg::A_MTHR, 32'h8);
        s = nfl;
        cmd(7'h10, 24'h0, 1'b0, 24'hc, 3'h3, 8'h0);
        chk(nfl != s, 1'b1);
        wr(tpw_pkg::A_MTHR, 32'h80000);
        for (p = 0; p < 7; p++) begin
            cmd(7'h10, 24'h0, 1'b0, 24'h4, 3'h3, 8'h0);
            flush_by(20, 1'b0);
            wr(tpw_pkg::A_OTHER, ops[p]);
            flush_by(20, p < 6);
        end
        unload_btn_i <= 1'b1;
        flush_by(20, 1'b1);
        unload_btn_i <= 1'b0;
        wr(tpw_pkg::A_WDELAY, 32'h3);
        cmd(7'h10, 24'h0, 1'b0, 24'h4, 3'h3, 8'h0);
        flush_by(60, 1'b0);
        cmd(7'h14, 24'h0, 1'b0, 24'h4, 3'h3, 8'h0);
        flush_by(60, 1'b1);
        wr(tpw_pkg::A_WDELAY, 32'h0);
        s = ndc;
        cmd(7'h1c, 24'h0, 1'b0, 24'h4, 3'h3, 8'h0);
        chk(ndc != s, 1'b1);
        flush_by(60, 1'b0);
        test_done();
    end
    // a hang ends the run as a failure
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire
